// ### rtl/cgr_bank.sv
/*
 * Register bank for the serial-link check code and the seven general
 * pins, with the active-low conversion-ready line it sequences.
 * Assumes the serial engine presents decoded single-cycle register
 * accesses on core_clk, flags each byte it shifts out, and flags reads
 * of the result low byte; pins arrive asynchronously.
 */
// Function
// - Check code runs only when enable set
// - Default: ready released after low byte read
// - Select set: release after check value read
// - Writing check value clears running code
// - Reading check value returns current code
// - Direction bit picks input or output
// - Pin six carrying ready is not general
// - Output pin follows its data bit
// - Data read returns level on pins
// - Data writes to input pins ignored
// - Ready release clears code unless disabled
// - Pin six carries ready when selected
`timescale 1ns/100ps

module cgr_bank (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [6:0] reg_addr,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic tx_byte_valid,
   input wire logic [7:0] tx_byte,
   input wire logic result_ready,
   input wire logic result_low_read,
   output logic conversion_ready_n,
   input wire logic [6:0] general_pin_in,
   output logic [6:0] general_pin_out,
   output logic [6:0] general_pin_oe
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [7:0] check_control;
      logic [7:0] ready_control;
      logic [6:0] pin_direction;
      logic [6:0] pin_data;
      logic [7:0] check_value;
      cgr_pkg::cgr_ready_state_type ready_state;
      logic ready_n;
      logic [7:0] rdata;
      logic [6:0] pin_out;
      logic [6:0] pin_oe;
      logic [6:0] pin_sync1;
      logic [6:0] pin_sync2;
   } cgr_state_type;

   cgr_state_type state;
   cgr_state_type next_state;
   logic [7:0] stepped_value;

   cgr_check_step check_step (
      .crc_in(state.check_value),
      .data_byte(tx_byte),
      .crc_out(stepped_value)
   );

   function automatic logic hit(input logic [6:0] addr,
                                input logic [6:0] target);
      hit = (addr == target);
   endfunction : hit

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      logic release_now;
      logic ready_on_six;
      logic [6:0] pin_level;
      next_state = state;
      release_now = 1'b0;
      ready_on_six = state.ready_control[cgr_pkg::READY_ON_PIN_SIX_BIT];
      pin_level = state.pin_sync2;

      // Pins pass two flops before anything reads them
      next_state.pin_sync1 = general_pin_in;
      next_state.pin_sync2 = state.pin_sync1;

      // Register writes
      if (reg_write) begin
         if (hit(reg_addr, cgr_pkg::ADDR_CHECK_CODE_CONTROL)) begin
            // Bit three is stored as written; host keeps it zero
            next_state.check_control =
               reg_wdata & cgr_pkg::CHECK_CODE_CONTROL_MASK;
         end
         if (hit(reg_addr, cgr_pkg::ADDR_READY_CONTROL)) begin
            next_state.ready_control =
               reg_wdata & cgr_pkg::READY_CONTROL_MASK;
         end
         if (hit(reg_addr, cgr_pkg::ADDR_GENERAL_PIN_DIRECTION)) begin
            next_state.pin_direction = reg_wdata[6:0];
         end
         if (hit(reg_addr, cgr_pkg::ADDR_GENERAL_PIN_DATA)) begin
            // Only output pins take the new level
            next_state.pin_data = (reg_wdata[6:0] & state.pin_direction)
               | (state.pin_data & ~state.pin_direction);
         end
      end

      // Conversion-ready sequencing
      unique case (state.ready_state)
         cgr_pkg::READY_RELEASED: begin
            if (result_ready) begin
               next_state.ready_state = cgr_pkg::READY_ASSERTED;
            end
         end
         cgr_pkg::READY_ASSERTED: begin
            if (result_low_read) begin
               if (state.check_control
                     [cgr_pkg::READY_RELEASE_AFTER_CHECK_BIT]) begin
                  next_state.ready_state = cgr_pkg::READY_WAIT_CHECK;
               end else begin
                  release_now = 1'b1;
               end
            end
         end
         cgr_pkg::READY_WAIT_CHECK: begin
            if (reg_read
                  && hit(reg_addr, cgr_pkg::ADDR_CHECK_CODE_VALUE)) begin
               release_now = 1'b1;
            end
         end
      endcase
      if (release_now) begin
         // A new result in the release cycle keeps the line low
         if (result_ready) begin
            next_state.ready_state = cgr_pkg::READY_ASSERTED;
         end else begin
            next_state.ready_state = cgr_pkg::READY_RELEASED;
         end
      end
      next_state.ready_n =
         (next_state.ready_state == cgr_pkg::READY_RELEASED);

      // Running check code; clears win over a byte in the same cycle
      if (tx_byte_valid
            && state.check_control[cgr_pkg::CHECK_ENABLE_BIT]) begin
         next_state.check_value = stepped_value;
      end
      if (release_now
            && !state.ready_control[cgr_pkg::CHECK_CLEAR_DISABLE_BIT]) begin
         next_state.check_value = cgr_pkg::CHECK_INITIAL;
      end
      if (reg_write && hit(reg_addr, cgr_pkg::ADDR_CHECK_CODE_VALUE)) begin
         next_state.check_value = cgr_pkg::CHECK_INITIAL;
      end

      // Register reads, one cycle latency
      next_state.rdata = 8'h00;
      if (reg_read) begin
         if (hit(reg_addr, cgr_pkg::ADDR_CHECK_CODE_CONTROL)) begin
            next_state.rdata = state.check_control;
         end
         if (hit(reg_addr, cgr_pkg::ADDR_READY_CONTROL)) begin
            next_state.rdata = state.ready_control;
         end
         if (hit(reg_addr, cgr_pkg::ADDR_CHECK_CODE_VALUE)) begin
            next_state.rdata = state.check_value;
         end
         if (hit(reg_addr, cgr_pkg::ADDR_GENERAL_PIN_DIRECTION)) begin
            next_state.rdata = {1'b0, state.pin_direction};
         end
         if (hit(reg_addr, cgr_pkg::ADDR_GENERAL_PIN_DATA)) begin
            next_state.rdata = {1'b0, pin_level};
         end
      end

      // Pin drivers; a fresh pin-six select takes effect with the write
      ready_on_six = next_state.ready_control[cgr_pkg::READY_ON_PIN_SIX_BIT];
      next_state.pin_out = next_state.pin_data;
      next_state.pin_oe = next_state.pin_direction;
      if (ready_on_six) begin
         // The ready line owns pin six outright
         next_state.pin_out[cgr_pkg::READY_PIN] = next_state.ready_n;
         next_state.pin_oe[cgr_pkg::READY_PIN] = 1'b1;
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state.check_control <= cgr_pkg::CHECK_CODE_CONTROL_RESET;
         state.ready_control <= cgr_pkg::READY_CONTROL_RESET;
         state.pin_direction <= cgr_pkg::PIN_DIRECTION_RESET;
         state.pin_data <= cgr_pkg::PIN_DATA_RESET;
         state.check_value <= cgr_pkg::CHECK_INITIAL;
         state.ready_state <= cgr_pkg::READY_RELEASED;
         state.ready_n <= 1'b1;
         state.rdata <= 8'h00;
         state.pin_out <= 7'h00;
         state.pin_oe <= 7'h00;
         state.pin_sync1 <= 7'h00;
         state.pin_sync2 <= 7'h00;
      end else begin
         state <= next_state;
      end
   end

   assign reg_rdata = state.rdata;
   assign conversion_ready_n = state.ready_n;
   assign general_pin_out = state.pin_out;
   assign general_pin_oe = state.pin_oe;

endmodule : cgr_bank

// ### rtl/cgr_pkg.sv
/*
 * Shared constants for the check-code and general-pin register bank:
 * register offsets, field positions, reset values and check-code setup.
 * Assumes a byte-wide register space with 7-bit addresses.
 */
package cgr_pkg;

   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [6:0] ADDR_GENERAL_PIN_DIRECTION = 7'h0e;
   localparam logic [6:0] ADDR_GENERAL_PIN_DATA = 7'h0f;
   localparam logic [6:0] ADDR_READY_CONTROL = 7'h11;
   localparam logic [6:0] ADDR_CHECK_CODE_CONTROL = 7'h13;
   localparam logic [6:0] ADDR_CHECK_CODE_VALUE = 7'h1d;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int CHECK_ENABLE_BIT = 4;
   localparam int CHECK_RESERVED_BIT = 3;
   localparam int READY_RELEASE_AFTER_CHECK_BIT = 2;
   localparam int READY_ON_PIN_SIX_BIT = 7;
   localparam int CHECK_CLEAR_DISABLE_BIT = 5;
   localparam int PIN_COUNT = 7;
   localparam int READY_PIN = 6;

   // ************************************************************
   // Reset values and writable masks
   // ************************************************************
   localparam logic [7:0] CHECK_CODE_CONTROL_RESET = 8'h00;
   localparam logic [7:0] CHECK_CODE_CONTROL_MASK = 8'h1c;
   localparam logic [7:0] READY_CONTROL_RESET = 8'h03;
   localparam logic [7:0] READY_CONTROL_MASK = 8'haf;
   localparam logic [6:0] PIN_DIRECTION_RESET = 7'h00;
   localparam logic [6:0] PIN_DATA_RESET = 7'h00;

   // ************************************************************
   // Check code setup
   // ************************************************************
   localparam logic [7:0] CHECK_POLYNOMIAL = 8'h07;
   localparam logic [7:0] CHECK_INITIAL = 8'h00;

   // ************************************************************
   // Conversion-ready sequencing
   // ************************************************************
   typedef enum logic [2:0] {
      READY_RELEASED = 3'b001,
      READY_ASSERTED = 3'b010,
      READY_WAIT_CHECK = 3'b100
   } cgr_ready_state_type;

endpackage : cgr_pkg

// ### rtl/cgr_check_step.sv
/*
 * One byte step of the check code: folds a byte into the running value,
 * most significant bit first. Purely combinational.
 * Assumes the caller registers the result.
 */
`timescale 1ns/100ps

module cgr_check_step (
   input wire logic [7:0] crc_in,
   input wire logic [7:0] data_byte,
   output logic [7:0] crc_out
);

   always_comb begin
      logic [7:0] acc;
      acc = crc_in ^ data_byte;
      for (int i = 0; i < 8; i++) begin
         if (acc[7]) begin
            acc = {acc[6:0], 1'b0} ^ cgr_pkg::CHECK_POLYNOMIAL;
         end else begin
            acc = {acc[6:0], 1'b0};
         end
      end
      crc_out = acc;
   end

endmodule : cgr_check_step

// ### tb/cgr_pin_world.sv
/* Outside world seen by the seven general pins of cgr_bank.
   Assumes oe high means the bank drives that pin. */
`timescale 1ns/100ps

module cgr_pin_world (
   input wire logic [6:0] pin_oe,
   input wire logic [6:0] pin_out,
   input wire logic [6:0] ext_level,
   output logic [6:0] pin_level
);
   // Undriven pins show the outside level, never a stale bank value
   assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : cgr_pin_world

// ### tb/cgr_bank_monitor.sv
/* Concurrent checks on the ports of cgr_bank, bound to every instance.
   Assumes one core_clk domain and a synchronous srst. */
`timescale 1ns/100ps

module cgr_bank_monitor (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [6:0] reg_addr,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic tx_byte_valid,
   input wire logic result_ready,
   input wire logic result_low_read,
   input wire logic conversion_ready_n,
   input wire logic [6:0] general_pin_in,
   input wire logic [6:0] general_pin_out,
   input wire logic [6:0] general_pin_oe
);
   // ****
   // Shadow of control bits
   // ****
   logic on6, aft;
   wire wdat = reg_write && reg_addr == cgr_pkg::ADDR_GENERAL_PIN_DATA;
   wire wdir = reg_write && reg_addr == cgr_pkg::ADDR_GENERAL_PIN_DIRECTION;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         on6 <= 1'b0;
         aft <= 1'b0;
      end else if (reg_write) begin
         if (reg_addr == cgr_pkg::ADDR_READY_CONTROL)
            on6 <= reg_wdata[7];
         if (reg_addr == cgr_pkg::ADDR_CHECK_CODE_CONTROL)
            aft <= reg_wdata[2];
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   sequence clr_s;
      reg_write && reg_addr == cgr_pkg::ADDR_CHECK_CODE_VALUE;
   endsequence
   sequence rd_val_s;
      reg_read && reg_addr == cgr_pkg::ADDR_CHECK_CODE_VALUE;
   endsequence
   sequence pin_rd_s;
      $stable(general_pin_in) [*3] ##0
         reg_read && reg_addr == cgr_pkg::ADDR_GENERAL_PIN_DATA;
   endsequence
   ready_set_a: assert property (result_ready |=> !conversion_ready_n)
      else $error("ready line not low after new result");
   low_release_a: assert property (
      !aft && result_low_read && !result_ready |=> conversion_ready_n)
      else $error("ready line not released after low byte");
   check_hold_a: assert property (
      aft && result_low_read && !conversion_ready_n && !reg_read
      |=> !conversion_ready_n)
      else $error("ready line released before check read");
   code_clear_a: assert property (
      clr_s ##1 !tx_byte_valid ##1 rd_val_s |=> reg_rdata == 8'h00)
      else $error("check code not cleared by write");
   pin_dir_a: assert property (
      wdir |=> general_pin_oe[5:0] == $past(reg_wdata[5:0]))
      else $error("pin enables do not follow direction");
   pin_drive_a: assert property (wdat |=> ((general_pin_out ^
      $past(reg_wdata[6:0])) & general_pin_oe & 7'h3f) == 7'h00)
      else $error("output pin level differs from data");
   input_keep_a: assert property (wdat |=> ((general_pin_out ^
      $past(general_pin_out)) & ~general_pin_oe & 7'h3f) == 7'h00)
      else $error("input pin data changed by write");
   pin_read_a: assert property (
      pin_rd_s |=> reg_rdata == {1'b0, $past(general_pin_in)})
      else $error("data read differs from pin levels");
   ready_pin_a: assert property (on6 |-> general_pin_oe[6] &&
      general_pin_out[6] == conversion_ready_n)
      else $error("pin six does not carry ready line");
endmodule : cgr_bank_monitor

bind cgr_bank cgr_bank_monitor i_cgr_bank_monitor (.core_clk(core_clk),
   .srst(srst), .reg_addr(reg_addr), .reg_write(reg_write),
   .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .tx_byte_valid(tx_byte_valid),
   .result_ready(result_ready), .result_low_read(result_low_read),
   .conversion_ready_n(conversion_ready_n),
   .general_pin_in(general_pin_in), .general_pin_out(general_pin_out),
   .general_pin_oe(general_pin_oe));

// ### tb/test_crc_and_gpio_registers.sv
/* Self-checking bench for cgr_bank with its pin-side world.
   Assumes a 100 MHz core_clk and a synchronous active-high srst. */
`timescale 1ns/100ps

module test_crc_and_gpio_registers;
   localparam logic [6:0] DIR = cgr_pkg::ADDR_GENERAL_PIN_DIRECTION;
   logic core_clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0;
   logic tv = 1'b0, rr = 1'b0, lr = 1'b0, rdy_n;
   logic [6:0] addr = 7'h00, ext = 7'h2a, pin, pout, poe;
   logic [7:0] wd = 8'h00, tx = 8'h00, rdat;
   int failures = 0, check_count = 0;
   always #5 core_clk = ~core_clk;
   cgr_bank i_cgr_bank (.core_clk(core_clk), .srst(srst), .reg_addr(addr),
      .reg_write(wr), .reg_read(rd), .reg_wdata(wd), .reg_rdata(rdat),
      .tx_byte_valid(tv), .tx_byte(tx), .result_ready(rr),
      .result_low_read(lr), .conversion_ready_n(rdy_n),
      .general_pin_in(pin), .general_pin_out(pout), .general_pin_oe(poe));
   cgr_pin_world i_cgr_pin_world (.pin_oe(poe), .pin_out(pout),
      .ext_level(ext), .pin_level(pin));
   // ****
   // Shared tasks
   // ****
   task chk(input string n, input logic [7:0] s, input logic [7:0] e);
      check_count++;
      if (s !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task close_out;
      $display("checks %0d errors %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : close_out
   task wr_reg(input logic [6:0] a, input logic [7:0] d);
      @(posedge core_clk) #1;
      addr = a;
      wd = d;
      wr = 1'b1;
      @(posedge core_clk) #1;
      wr = 1'b0;
   endtask : wr_reg
   task rd_reg(input logic [6:0] a, input string n, input logic [7:0] e);
      @(posedge core_clk) #1;
      addr = a;
      rd = 1'b1;
      @(posedge core_clk) #1;
      rd = 1'b0;
      chk(n, rdat, e);
   endtask : rd_reg
   // One-cycle pulse of {low read, new result, shifted byte}
   task ev(input logic [2:0] m, input logic [7:0] b);
      @(posedge core_clk) #1;
      {lr, rr, tv} = m;
      tx = b;
      @(posedge core_clk) #1;
      {lr, rr, tv} = 3'b000;
   endtask : ev
   // ****
   // Scenarios
   // ****
   task t_reset;
      rd_reg(7'h13, "code ctl", 8'h00);
      rd_reg(7'h11, "ready ctl", 8'h03);
      rd_reg(DIR, "pin dir", 8'h00);
      rd_reg(7'h20, "unmapped", 8'h00);
   endtask : t_reset
   task t_code;
      ev(3'b001, 8'h01);
      rd_reg(7'h1d, "code off", 8'h00);
      wr_reg(7'h13, 8'h10);
      ev(3'b001, 8'h01);
      rd_reg(7'h1d, "code on", 8'h07);
      wr_reg(7'h1d, 8'h5a);
      rd_reg(7'h1d, "code cleared", 8'h00);
   endtask : t_code
   task t_ready;
      ev(3'b001, 8'h01);
      ev(3'b010, 8'h00);
      chk("ready set", {7'h00, rdy_n}, 8'h00);
      ev(3'b100, 8'h00);
      chk("ready free", {7'h00, rdy_n}, 8'h01);
      rd_reg(7'h1d, "code reset", 8'h00);
      wr_reg(7'h11, 8'h23);
      wr_reg(7'h13, 8'h14);
      ev(3'b001, 8'h01);
      ev(3'b001, 8'h01);
      ev(3'b010, 8'h00);
      ev(3'b100, 8'h00);
      chk("ready held", {7'h00, rdy_n}, 8'h00);
      rd_reg(7'h1d, "code value", 8'h12);
      chk("ready late", {7'h00, rdy_n}, 8'h01);
      rd_reg(7'h1d, "code kept", 8'h12);
   endtask : t_ready
   task t_pins;
      wr_reg(DIR, 8'h7f);
      wr_reg(7'h0f, 8'h55);
      chk("pin out", {1'b0, pout}, 8'h55);
      chk("pin oe", {1'b0, poe}, 8'h7f);
      // Pins pass a two-flop synchroniser before readback
      repeat (2) @(posedge core_clk);
      rd_reg(7'h0f, "pin read", 8'h55);
      wr_reg(DIR, 8'h0f);
      wr_reg(7'h0f, 8'h00);
      repeat (2) @(posedge core_clk);
      rd_reg(7'h0f, "pin mix", 8'h20);
      wr_reg(DIR, 8'h7f);
      chk("pin keep", {1'b0, pout}, 8'h50);
      wr_reg(DIR, 8'h3f);
      wr_reg(7'h11, 8'h83);
      ev(3'b010, 8'h00);
      chk("six level", {7'h00, pout[6]}, 8'h00);
      chk("six oe", {7'h00, poe[6]}, 8'h01);
   endtask : t_pins
   initial begin
      repeat (16) @(posedge core_clk);
      #1 srst = 1'b0;
      t_reset();
      t_code();
      t_ready();
      t_pins();
      close_out();
   end
   initial begin
      #100000;
      failures++;
      close_out();
   end
endmodule : test_crc_and_gpio_registers
